// *** rtl/ccount_defs.svh ***
// Constants for the charge counter: register map, fields, timing.
// Assumes a 100 MHz core clock, 24-bit registers and 32-bit serial frames.
`ifndef CCOUNT_DEFS_SVH
`define CCOUNT_DEFS_SVH

`define CC_ADDR_W 6
`define CC_DATA_W 24
`define CC_REG_CTRL 6'h09
`define CC_REG_PRESC 6'h0A

`define CC_BIT_RUN 0
`define CC_BIT_RST 1
`define CC_BIT_DCALDIS 2
`define CC_BIT_ACAL 3
`define CC_BIT_DITHER 4
`define CC_BIT_FAULT 7
`define CC_CNT_LSB 8
`define CC_CNT_MSB 23
`define CC_PRESC_MSB 14

`define CC_CNT_W 16
`define CC_PRESC_W 15
`define CC_PRESC_RST 15'h0001
`define CC_ROLL_VAL 16'h8000

`define CC_CLK_PERIOD_NS 10
`define CC_RST_TIME_NS 40000
`define CC_RST_CYCLES (`CC_RST_TIME_NS / `CC_CLK_PERIOD_NS)
`define CC_RST_CW 12
`define CC_DEB_TIME_MS 1000
`define CC_DEB_CYCLES (`CC_DEB_TIME_MS * (1000000 / `CC_CLK_PERIOD_NS))

`define CC_SPI_FRAME 32
`define CC_SPI_DATA_START 8
`define CC_SPI_CNT_W 6

`endif

// *** rtl/ccount_pkg.sv ***
// Types shared by the charge counter modules.
// Assumes the constants header is compiled alongside.
package ccount_pkg;
    typedef enum logic {RST_IDLE, RST_BUSY} rst_state_t;
    typedef logic [5:0] reg_addr_t;
    typedef logic [23:0] reg_data_t;
endpackage

// *** rtl/charge_counter.sv ***
// Digital core of the battery charge counter with its serial register port.
// Assumes converter, comparator and serial pins are asynchronous to clk_in.
`timescale 1ns/10ps
`include "ccount_defs.svh"
module charge_counter #(
    parameter int unsigned DEBOUNCE_CYCLES = `CC_DEB_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic conv_toggle_in,
    input wire logic conv_down_in,
    input wire logic supply_below_uv_in,
    input wire logic battery_detect_sense_in,
    output logic counter_run_out,
    output logic converter_reset_out,
    output logic digital_corr_en_out,
    output logic analog_short_out,
    output logic dither_out
);
    import ccount_pkg::*;
    localparam int RST_MAX = `CC_RST_CYCLES;

    reg_addr_t spi_addr;
    reg_data_t rd_data, wr_data;
    logic spi_wr, ctrl_wr, presc_wr;

    logic counter_run_r, digital_cal_disable_r, analog_cal_enable_r, dither_enable_r;
    logic count_invalid_flag_r;
    logic [`CC_PRESC_W-1:0] count_prescale_r;
    logic signed [`CC_CNT_W-1:0] charge_count_r, charge_count_nxt;
    logic signed [`CC_PRESC_W:0] sub_r, sub_nxt, limit;
    rst_state_t rst_state_r;
    logic [`CC_RST_CW-1:0] rst_timer_r;
    logic rst_busy;
    // Independent length of the busy period, only for the period check
    logic [`CC_RST_CW-1:0] busy_len_r;

    logic [3:0] sync1_r, sync2_r;
    logic toggle_d_r, step, step_down;
    logic uv_hit, batt_hit, roll_hit, fault_set;

    spi_frame u_spi (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .addr_out(spi_addr),
        .rd_data_in(rd_data),
        .wr_out(spi_wr),
        .wr_data_out(wr_data)
    );

    assign ctrl_wr = spi_wr && spi_addr == `CC_REG_CTRL;
    assign presc_wr = spi_wr && spi_addr == `CC_REG_PRESC;

    // Converter and comparator inputs: two flops before any use
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            toggle_d_r <= 1'b0;
        end else begin
            sync1_r <= {battery_detect_sense_in, supply_below_uv_in, conv_down_in,
                        conv_toggle_in};
            sync2_r <= sync1_r;
            toggle_d_r <= sync2_r[0];
        end
    end
    // Each converter count arrives as a toggle so no pulse is lost across domains
    assign step = sync2_r[0] ^ toggle_d_r;
    assign step_down = sync2_r[1];

    level_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_uv_deb (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .level_in(sync2_r[2]),
        .hit_out(uv_hit)
    );

    level_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_batt_deb (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .level_in(sync2_r[3]),
        .hit_out(batt_hit)
    );

    // Control bits
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            counter_run_r <= 1'b0;
        end else if (ctrl_wr) begin
            counter_run_r <= wr_data[`CC_BIT_RUN];
        end
    end

    // Correction stays on after reset; turning it off is a user choice
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            digital_cal_disable_r <= 1'b0;
        end else if (ctrl_wr) begin
            digital_cal_disable_r <= wr_data[`CC_BIT_DCALDIS];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            analog_cal_enable_r <= 1'b0;
        end else if (ctrl_wr) begin
            analog_cal_enable_r <= wr_data[`CC_BIT_ACAL];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dither_enable_r <= 1'b0;
        end else if (ctrl_wr) begin
            dither_enable_r <= wr_data[`CC_BIT_DITHER];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_prescale_r <= `CC_PRESC_RST;
        end else if (presc_wr) begin
            count_prescale_r <= wr_data[`CC_PRESC_MSB:0];
        end
    end

    // Self-clearing reset command; settings survive it, only counting logic clears
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rst_state_r <= RST_IDLE;
            rst_timer_r <= '0;
        end else begin
            unique case (rst_state_r)
                RST_IDLE: begin
                    rst_timer_r <= '0;
                    if (ctrl_wr && wr_data[`CC_BIT_RST]) begin
                        rst_state_r <= RST_BUSY;
                    end
                end
                RST_BUSY: begin
                    rst_timer_r <= `CC_RST_CW'(rst_timer_r + 1'b1);
                    if (rst_timer_r == `CC_RST_CW'(`CC_RST_CYCLES - 1)) begin
                        rst_state_r <= RST_IDLE;
                    end
                end
            endcase
        end
    end
    assign rst_busy = rst_state_r == RST_BUSY;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rst_busy) begin
            busy_len_r <= '0;
        end else begin
            busy_len_r <= `CC_RST_CW'(busy_len_r + 1'b1);
        end
    end

    // Wrap test for either direction; >= so a smaller limit can never stall the count
    function automatic logic residue_full(input logic signed [`CC_PRESC_W:0] res,
            input logic signed [`CC_PRESC_W:0] lim);
        return res >= lim - 16'sh0001;
    endfunction

    // Prescaler: residue runs both ways, so mixed charge and discharge nets out
    always_comb begin
        limit = (count_prescale_r == '0) ? 16'sh0001 : $signed({1'b0, count_prescale_r});
        sub_nxt = sub_r;
        charge_count_nxt = charge_count_r;
        if (step && !step_down) begin
            if (residue_full(sub_r, limit)) begin
                sub_nxt = '0;
                charge_count_nxt = charge_count_r + 16'sh0001;
            end else begin
                sub_nxt = sub_r + 16'sh0001;
            end
        end else if (step) begin
            if (residue_full(-sub_r, limit)) begin
                sub_nxt = '0;
                charge_count_nxt = charge_count_r - 16'sh0001;
            end else begin
                sub_nxt = sub_r - 16'sh0001;
            end
        end
    end

    // Stopped counter holds count and residue; a new scale drops the old residue
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || rst_busy) begin
            charge_count_r <= '0;
            sub_r <= '0;
        end else begin
            if (counter_run_r) begin
                charge_count_r <= charge_count_nxt;
            end
            if (presc_wr) begin
                sub_r <= '0;
            end else if (counter_run_r) begin
                sub_r <= sub_nxt;
            end
        end
    end

    assign roll_hit = counter_run_r && !rst_busy && charge_count_nxt == `CC_ROLL_VAL
        && charge_count_r != `CC_ROLL_VAL;
    assign fault_set = roll_hit || uv_hit || batt_hit;

    // Status only; deliberately no interrupt path
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_invalid_flag_r <= 1'b0;
        end else if (ctrl_wr) begin
            count_invalid_flag_r <= fault_set
                || (count_invalid_flag_r && wr_data[`CC_BIT_FAULT]);
        end else begin
            count_invalid_flag_r <= count_invalid_flag_r || fault_set;
        end
    end

    // Read data; the control word carries the count, so writes return it too
    always_comb begin
        rd_data = '0;
        if (spi_addr == `CC_REG_CTRL) begin
            rd_data[`CC_BIT_RUN] = counter_run_r;
            rd_data[`CC_BIT_RST] = rst_busy;
            rd_data[`CC_BIT_DCALDIS] = digital_cal_disable_r;
            rd_data[`CC_BIT_ACAL] = analog_cal_enable_r;
            rd_data[`CC_BIT_DITHER] = dither_enable_r;
            rd_data[`CC_BIT_FAULT] = count_invalid_flag_r;
            rd_data[`CC_CNT_MSB:`CC_CNT_LSB] = charge_count_r;
        end else if (spi_addr == `CC_REG_PRESC) begin
            rd_data[`CC_PRESC_MSB:0] = count_prescale_r;
        end
    end

    assign counter_run_out = counter_run_r;
    assign converter_reset_out = rst_busy;
    assign digital_corr_en_out = !digital_cal_disable_r;
    assign analog_short_out = analog_cal_enable_r;
    assign dither_out = dither_enable_r && !digital_cal_disable_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_presc_reset_one: assert property ($past(!rst_n_in) |-> count_prescale_r == `CC_PRESC_RST)
        else $error("prescale not one after reset");
    a_presc_written: assert property (presc_wr
        |=> count_prescale_r == $past(wr_data[`CC_PRESC_MSB:0]))
        else $error("prescale write lost");
    a_reset_clears_count: assert property (rst_busy |=> charge_count_r == 16'h0000)
        else $error("count not cleared during reset");
    a_reset_keeps_settings: assert property (rst_busy && !presc_wr
        |=> $stable(count_prescale_r))
        else $error("reset command changed prescale");
    // Period bounded by a counter, too long for a delay range
    a_reset_self_clear: assert property (busy_len_r == `CC_RST_CW'(RST_MAX - 1)
        |=> !rst_busy)
        else $error("reset command did not clear in time");
    a_reset_full_length: assert property (rst_busy && busy_len_r < `CC_RST_CW'(RST_MAX - 1)
        |=> rst_busy)
        else $error("reset period ended early");
    a_busy_bit_read: assert property (spi_addr == `CC_REG_CTRL
        |-> rd_data[`CC_BIT_RST] == rst_busy)
        else $error("busy bit not readable");
    a_run_from_write: assert property (ctrl_wr
        |=> counter_run_out == $past(wr_data[`CC_BIT_RUN]))
        else $error("run bit write lost");
    a_short_from_write: assert property (ctrl_wr
        |=> analog_short_out == $past(wr_data[`CC_BIT_ACAL]))
        else $error("calibration short write lost");
    a_stop_holds_count: assert property (!counter_run_r && !rst_busy |=> $stable(charge_count_r))
        else $error("stopped counter changed");
    a_unit_step_up: assert property (counter_run_r && !rst_busy && step && !step_down
        && count_prescale_r == 15'h0001 |=> charge_count_r == $past(charge_count_r) + 16'sd1)
        else $error("unit prescale did not step");
    a_unit_step_down: assert property (counter_run_r && !rst_busy && step && step_down
        && count_prescale_r == `CC_PRESC_RST && !presc_wr
        |=> charge_count_r == $past(charge_count_r) - 16'sh0001)
        else $error("unit prescale did not step down");
    a_dither_needs_cal: assert property (digital_cal_disable_r |-> !dither_out)
        else $error("dither with correction off");
    a_roll_sets_flag: assert property (roll_hit |=> count_invalid_flag_r
        && charge_count_r == 16'h8000)
        else $error("rollover not flagged");
    a_flag_latched: assert property (count_invalid_flag_r && !ctrl_wr |=> count_invalid_flag_r)
        else $error("flag dropped without clear");
    a_set_beats_clear: assert property (ctrl_wr && !wr_data[`CC_BIT_FAULT] && fault_set
        |=> count_invalid_flag_r)
        else $error("clear won over fault");
    a_flag_clear_write: assert property (ctrl_wr && !wr_data[`CC_BIT_FAULT] && !fault_set
        |=> !count_invalid_flag_r)
        else $error("flag clear write ignored");
    a_uv_sets_flag: assert property (uv_hit |=> count_invalid_flag_r)
        else $error("undervoltage not flagged");
    a_batt_sets_flag: assert property (batt_hit |=> count_invalid_flag_r)
        else $error("battery removal not flagged");
    a_ctrl_read_count: assert property (spi_addr == `CC_REG_CTRL
        |-> rd_data[`CC_CNT_MSB:`CC_CNT_LSB] == charge_count_r)
        else $error("control word lacks count");

    c_rollover: cover property (roll_hit);
    c_reset_done: cover property ($fell(rst_busy));
    c_flag_cleared: cover property ($fell(count_invalid_flag_r));
    c_down_step: cover property (counter_run_r && step && step_down);
    c_presc_write: cover property (presc_wr);
endmodule

// *** rtl/level_debounce.sv ***
// Debounce of a synchronised level: one pulse after a long steady high.
// Assumes the input is already in the clk_in domain.
`timescale 1ns/10ps
module level_debounce #(
    parameter int unsigned CYCLES = 100000000
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic level_in,
    output logic hit_out
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;

    // Saturates so one long fault gives one pulse only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !level_in) begin
            cnt_r <= '0;
        end else if (cnt_r != CW'(CYCLES)) begin
            cnt_r <= CW'(cnt_r + 1'b1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hit_out <= 1'b0;
        end else begin
            hit_out <= level_in && (cnt_r == CW'(CYCLES - 1));
        end
    end
endmodule

// *** rtl/spi_frame.sv ***
// Serial register port: 32-bit frames, write flag, 6-bit address, pad, 24 data.
// Assumes the serial clock is well below a quarter of clk_in; mode 0, MSB first.
`timescale 1ns/10ps
`include "ccount_defs.svh"
module spi_frame (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    output ccount_pkg::reg_addr_t addr_out,
    input wire ccount_pkg::reg_data_t rd_data_in,
    output logic wr_out,
    output ccount_pkg::reg_data_t wr_data_out
);
    import ccount_pkg::*;
    logic [2:0] sclk_s1_r, sclk_s2_r;
    logic sclk_d_r, rise, fall;
    logic [`CC_SPI_CNT_W-1:0] bit_cnt_r;
    logic [30:0] rx_r;
    reg_data_t tx_r;
    reg_addr_t addr_r;

    // Two-flop synchronisers; edges taken from the second stage only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sclk_s1_r <= 3'h4;
            sclk_s2_r <= 3'h4;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_s1_r <= {cs_n_in, mosi_in, sclk_in};
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r[0];
        end
    end
    assign rise = !sclk_s2_r[2] && sclk_s2_r[0] && !sclk_d_r;
    assign fall = !sclk_s2_r[2] && !sclk_s2_r[0] && sclk_d_r;
    // Address held after the header; the shifter moves on into the data field
    assign addr_out = (bit_cnt_r < `CC_SPI_CNT_W'(`CC_SPI_DATA_START)) ? rx_r[5:0] : addr_r;
    assign miso_oe_out = !sclk_s2_r[2];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || sclk_s2_r[2]) begin
            bit_cnt_r <= '0;
        end else if (rise && bit_cnt_r != `CC_SPI_CNT_W'(`CC_SPI_FRAME)) begin
            bit_cnt_r <= `CC_SPI_CNT_W'(bit_cnt_r + 1'b1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_r <= '0;
        end else if (rise) begin
            rx_r <= {rx_r[29:0], sclk_s2_r[1]};
        end
    end

    // Read data captured once the address is complete
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_r <= '0;
            addr_r <= '0;
        end else if (rise && bit_cnt_r == `CC_SPI_CNT_W'(`CC_SPI_DATA_START - 1)) begin
            tx_r <= rd_data_in;
            addr_r <= rx_r[5:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || sclk_s2_r[2]) begin
            miso_out <= 1'b0;
        end else if (fall) begin
            if (bit_cnt_r >= `CC_SPI_CNT_W'(`CC_SPI_DATA_START)
                    && bit_cnt_r < `CC_SPI_CNT_W'(`CC_SPI_FRAME)) begin
                miso_out <= tx_r[5'(`CC_SPI_CNT_W'(`CC_SPI_FRAME - 1) - bit_cnt_r)];
            end else begin
                miso_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_out <= 1'b0;
            wr_data_out <= '0;
        end else begin
            wr_out <= rise && bit_cnt_r == `CC_SPI_CNT_W'(`CC_SPI_FRAME - 1) && rx_r[30];
            wr_data_out <= {rx_r[22:0], sclk_s2_r[1]};
        end
    end
endmodule

// *** test/charge_counter_test.sv ***
// Self-checking bench for the charge counter through its serial port.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/10ps
module charge_counter_test;
    import ccount_pkg::*;
    logic clk_in, rst_n_in, sclk, cs_n, mosi, miso, miso_oe;
    logic conv_toggle, conv_down, uv, bds;
    logic run_o, crst_o, dcorr_o, ashort_o, dith_o;
    reg_data_t rd;
    int err_total, checks;

    charge_counter #(.DEBOUNCE_CYCLES(20)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
        .conv_toggle_in(conv_toggle), .conv_down_in(conv_down),
        .supply_below_uv_in(uv), .battery_detect_sense_in(bds),
        .counter_run_out(run_o), .converter_reset_out(crst_o),
        .digital_corr_en_out(dcorr_o), .analog_short_out(ashort_o), .dither_out(dith_o));

    spi_host_model host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        host.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdr(input reg_addr_t a);
        host.xfer(1'b0, a, 24'h000000, rd);
    endtask

    // Direction settles three cycles either side of every count edge
    task automatic conv_steps(input int n, input logic down);
        conv_down = down;
        for (int i = 0; i < n; i++) begin
            repeat (3) @(negedge clk_in);
            conv_toggle = ~conv_toggle;
        end
        repeat (3) @(negedge clk_in);
    endtask

    task automatic wait_busy_end;
        int n;
        n = 0;
        while (crst_o !== 1'b0 && n < 4100) begin
            @(negedge clk_in);
            n++;
        end
        check("busy_bound", {23'h000000, n <= 4000}, 24'h000001);
    endtask

    task automatic t_reset_vals;
        check("outs", {19'h00000, run_o, crst_o, dcorr_o, ashort_o, dith_o}, 24'h000004);
        check("oe_idle", {23'h000000, miso_oe}, 24'h000000);
        rdr(6'h09);
        check("ctrl_rst", rd, 24'h000000);
        rdr(6'h0A);
        check("presc_rst", rd, 24'h000001);
        rdr(6'h05);
        check("unmapped", rd, 24'h000000);
    endtask

    // Host bring-up order with calibration, then restart of the count
    task automatic t_init_cal;
        wr(6'h09, 24'h00001B);
        check("short", {23'h000000, ashort_o}, 24'h000001);
        rdr(6'h09);
        check("busy_bit", {23'h000000, rd[1]}, 24'h000001);
        wait_busy_end();
        conv_steps(4, 1'b0);
        rdr(6'h09);
        check("cal_count", rd, 24'h000419);
        wr(6'h0A, 24'h000003);
        wr(6'h09, 24'h000013);
        check("wr_echo", {8'h00, rd[23:8]}, 24'h000004);
        wait_busy_end();
        rdr(6'h09);
        check("cleared", rd, 24'h000011);
    endtask

    task automatic t_prescale;
        conv_steps(6, 1'b0);
        rdr(6'h09);
        check("presc_up", rd, 24'h000211);
        conv_steps(3, 1'b1);
        rdr(6'h09);
        check("presc_dn", rd, 24'h000111);
        wr(6'h0A, 24'h000001);
    endtask

    task automatic t_run_stop;
        wr(6'h09, 24'h000010);
        check("run_off", {23'h000000, run_o}, 24'h000000);
        conv_steps(3, 1'b0);
        rdr(6'h09);
        check("held", rd, 24'h000110);
        wr(6'h09, 24'h000011);
        conv_steps(2, 1'b0);
        rdr(6'h09);
        check("resumed", rd, 24'h000311);
    endtask

    task automatic t_cal_bits;
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            wr(6'h09, {16'h0000, 3'b000, k, 2'b01});
            check("dcorr", {23'h000000, dcorr_o}, {23'h000000, ~k[0]});
            check("ashort", {23'h000000, ashort_o}, {23'h000000, k[1]});
            check("dither", {23'h000000, dith_o}, {23'h000000, k[2] & ~k[0]});
        end
        wr(6'h09, 24'h000001);
    endtask

    // Long walk to the sign change; the count must carry on past it
    task automatic t_roll;
        conv_steps(32764, 1'b0);
        rdr(6'h09);
        check("before_roll", rd, 24'h7FFF01);
        conv_steps(1, 1'b0);
        rdr(6'h09);
        check("at_roll", rd, 24'h800081);
        conv_steps(1, 1'b0);
        wr(6'h09, 24'h000081);
        rdr(6'h09);
        check("latched", rd, 24'h800181);
        wr(6'h09, 24'h000001);
        rdr(6'h09);
        check("cleared_flag", rd, 24'h800101);
    endtask

    task automatic t_debounce(input int src);
        for (int len = 10; len <= 40; len += 30) begin
            if (src == 0) uv = 1'b1; else bds = 1'b1;
            repeat (len) @(negedge clk_in);
            uv = 1'b0;
            bds = 1'b0;
            rdr(6'h09);
            check("deb_flag", {23'h000000, rd[7]}, {23'h000000, len > 20});
        end
        wr(6'h09, 24'h000001);
        rdr(6'h09);
        check("deb_clear", {23'h000000, rd[7]}, 24'h000000);
    endtask

    initial begin
        repeat (150000) @(posedge clk_in);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        checks = 0;
        rst_n_in = 1'b0;
        conv_toggle = 1'b0;
        conv_down = 1'b0;
        uv = 1'b0;
        bds = 1'b0;
        repeat (12) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_reset_vals();
        t_init_cal();
        t_prescale();
        t_run_stop();
        t_cal_bits();
        t_roll();
        t_debounce(0);
        t_debounce(1);
        report_and_stop();
    end
endmodule

// *** test/spi_host_model.sv ***
// Host side of the serial register port: one 32-bit frame per call.
// Assumes the bench clock; serial clock idles low and stops between frames.
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    import ccount_pkg::*;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Five core cycles per serial half period keeps well inside the synchroniser limit
    task automatic xfer(input logic wr, input reg_addr_t addr, input reg_data_t wdata,
                        output reg_data_t rdata);
        logic [31:0] frame;
        frame = {wr, addr, 1'b0, wdata};
        rdata = 24'h000000;
        @(negedge clk_in);
        cs_n_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_out = frame[i];
            repeat (5) @(negedge clk_in);
            if (i < 24) begin
                rdata[i] = miso_in;
            end
            sclk_out = 1'b1;
            repeat (5) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        repeat (5) @(negedge clk_in);
        cs_n_out = 1'b1;
        // Released line: show the inverse so stale data cannot pass for a match
        mosi_out = ~mosi_out;
        repeat (6) @(negedge clk_in);
    endtask
endmodule
